// File: design/ctv_pkg.sv
// Package with command codes, field layout, limits and types of the timing command block.
package ctv_pkg;

  // ******************************
  // Command codes
  // ******************************
  localparam logic [7:0] CMD_SWITCHING_FREQ = 8'h33;
  localparam logic [7:0] CMD_TURN_ON_THR    = 8'h35;
  localparam logic [7:0] CMD_TURN_OFF_THR   = 8'h36;
  localparam logic [7:0] CMD_PHASE_PLACE    = 8'h37;

  // ******************************
  // Field layout
  // ******************************
  localparam int EXP_MSB   = 15;
  localparam int EXP_LSB   = 11;
  localparam int MAN_MSB   = 10;
  localparam int GROUP_LSB = 8;
  localparam int SIZE_LSB  = 4;
  localparam int POS_LSB   = 0;

  // ******************************
  // Reset values and limits
  // ******************************
  localparam logic [4:0]  THR_EXP_RST   = 5'h1e;
  localparam logic [15:0] FREQ_RST      = 16'h0000;
  localparam logic [15:0] THR_RST       = 16'hf000;
  localparam logic [11:0] PHASE_RST     = 12'h010;
  localparam int          THR_FRAC      = 2;
  localparam int          ON_MIN_Q      = 10;
  localparam int          OFF_MIN_Q     = 9;
  localparam int          THR_MAX_Q     = 73;
  localparam int          FREQ_MAX_KHZ  = 1649;
  localparam int          GROUP_MAX     = 4;
  localparam int          MANT_LIMIT    = 1024;

  // ******************************
  // Types
  // ******************************
  typedef struct packed {
    logic [10:0] fsw_khz;
    logic [6:0]  on_q;
    logic [6:0]  off_q;
    logic [8:0]  phase_deg;
  } ctv_hw_t;

  typedef struct packed {
    logic invalid_data;
    logic invalid_cmd;
    logic off_low_input;
  } ctv_status_t;

endpackage

// File: design/ctv_cmd_regs.sv
// Timing and input threshold command registers with hardware decode.
`timescale 1ns/1ns

// Notes on behaviour
// (R1) Frequency word: signed exponent 15:11, signed mantissa 10:0, value in kHz.
// (R2) Frequency reaches hardware at once if disabled, else after restore or supply drop.
// (R3) After reset the frequency exponent is rebuilt from the stored kHz value.
// (R4) Decoded frequency maps by band to 225 through 1500 kHz.
// (R5) Host avoids above 1100 kHz without external bias rail or when stacked.
// (R6) Turn-on threshold in volts; exponent resets to 11110b, meaning -2.
// (R7) Thresholds accept any valid value, floored to hardware step, also on restore.
// (R8) Turn-on hardware spans 2.50 V to 18.25 V in 0.25 V steps.
// (R9) Turn-off hardware spans 2.25 V to 18.25 V; exponent resets like turn-on.
// (R10) Low input fault masked until input first exceeds turn-on after power-on.
// (R11) Enabled but power input below turn-off sets the off-due-to-low-input bit.
// (R12) Out-of-range threshold writes are invalid data and flag status.
// (R13) Host keeps turn-off threshold below the turn-on threshold.
// (R14) Phase placement bits 15:12 read as zero and ignore writes.
// (R15) Phase fields: group 11:8, size 7:4 (1 to 4), position 3:0.
// (R16) Oscillator delay from sync is 360 degrees over size times position.
// (R17) Phase placement is writable only on a standalone device.
// (R18) Writability is latched from stacking at power-on and then held.
// (R19) Linear words decode as mantissa times two to the exponent first.
module ctv_cmd_regs (
  input  wire logic               sys_clk_i,
  input  wire logic               arst_n_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  input  wire logic [7:0]         cmd_i,
  input  wire logic [15:0]        wdata_i,
  input  wire logic               conv_en_i,
  input  wire logic               en_cond_met_i,
  input  wire logic               nvm_restore_i,
  input  wire logic               analog_supply_uvlo_i,
  input  wire logic               stacked_i,
  input  wire logic [10:0]        nvm_freq_khz_i,
  input  wire logic [15:0]        nvm_turn_on_i,
  input  wire logic [15:0]        nvm_turn_off_i,
  input  wire logic [11:0]        nvm_phase_i,
  input  wire logic [6:0]         power_stage_input_q_i,
  input  wire logic               status_clr_i,
  output logic [15:0]             rdata_o,
  output logic                    ack_o,
  output ctv_pkg::ctv_hw_t        hw_o,
  output ctv_pkg::ctv_status_t    status_o,
  output logic                    low_input_fault_o
);

  // ******************************
  // Decode functions
  // ******************************
  function automatic logic signed [31:0] lin_fixed(input logic [15:0] w, input int frac);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    int                 sh;
    e  = w[ctv_pkg::EXP_MSB:ctv_pkg::EXP_LSB];
    m  = w[ctv_pkg::MAN_MSB:0];
    sh = int'(e) + frac;
    if (sh > 15)
      sh = 15;
    if (sh >= 0)
      lin_fixed = 32'(m) <<< sh; // R19
    else
      lin_fixed = 32'(m) >>> (-sh); // R19 R7
  endfunction

  function automatic logic [10:0] freq_band(input logic signed [31:0] f);
    if (f < 250)
      freq_band = 11'd225; // R4
    else if (f < 300)
      freq_band = 11'd275;
    else if (f < 350)
      freq_band = 11'd325;
    else if (f < 410)
      freq_band = 11'd375;
    else if (f < 500)
      freq_band = 11'd450;
    else if (f < 600)
      freq_band = 11'd550;
    else if (f < 700)
      freq_band = 11'd650;
    else if (f < 820)
      freq_band = 11'd750;
    else if (f < 1000)
      freq_band = 11'd900;
    else if (f < 1200)
      freq_band = 11'd1100;
    else if (f < 1400)
      freq_band = 11'd1300;
    else
      freq_band = 11'd1500;
  endfunction

  function automatic logic thr_ok(input logic signed [31:0] q, input int lo);
    thr_ok = (q >= lo) && (q <= ctv_pkg::THR_MAX_Q);
  endfunction

  function automatic logic phase_ok(input logic [11:0] p);
    logic [3:0] sz;
    sz = p[ctv_pkg::SIZE_LSB +: 4];
    phase_ok = (sz != 4'h0) && (sz <= 4'(ctv_pkg::GROUP_MAX)) && (p[3:0] < sz);
  endfunction

  function automatic logic [15:0] thr_word(input logic signed [31:0] q);
    thr_word = {ctv_pkg::THR_EXP_RST, q[10:0]}; // R6 R9
  endfunction

  // ******************************
  // Boot, synchronisers and held configuration
  // ******************************
  logic        boot_r;
  logic        reload_d_r;
  logic        writable_r;
  logic [1:0]  uvlo_sync_r;
  logic        uvlo_prev_r;
  logic        reload;
  logic        uvlo_rise;

  // The supply comparator is analog, so it is synchronised before the edge detector.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      uvlo_sync_r <= 2'h0;
      uvlo_prev_r <= 1'b0;
    end
    else
    begin
      uvlo_sync_r <= {uvlo_sync_r[0], analog_supply_uvlo_i};
      uvlo_prev_r <= uvlo_sync_r[1];
    end
  end

  assign uvlo_rise = uvlo_sync_r[1] && !uvlo_prev_r;
  assign reload    = !boot_r || nvm_restore_i;

  // Stacking is caught once, at the first edge after reset release.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      boot_r     <= 1'b0;
      writable_r <= 1'b0;
      reload_d_r <= 1'b0;
    end
    else
    begin
      boot_r     <= 1'b1;
      reload_d_r <= reload;
      if (!boot_r)
        writable_r <= !stacked_i; // R18 R17
    end
  end

  // ******************************
  // Write decode
  // ******************************
  logic signed [31:0] wr_val_f;
  logic signed [31:0] wr_val_q;
  logic signed [31:0] nvm_on_q;
  logic signed [31:0] nvm_off_q;
  logic               wr_freq;
  logic               wr_on;
  logic               wr_off;
  logic               wr_phase;
  logic               wr_bad;
  logic               wr_unknown;

  always_comb
  begin
    wr_val_f   = lin_fixed(wdata_i, 0); // R1
    wr_val_q   = lin_fixed(wdata_i, ctv_pkg::THR_FRAC);
    nvm_on_q   = lin_fixed(nvm_turn_on_i, ctv_pkg::THR_FRAC);
    nvm_off_q  = lin_fixed(nvm_turn_off_i, ctv_pkg::THR_FRAC);
    wr_freq    = 1'b0;
    wr_on      = 1'b0;
    wr_off     = 1'b0;
    wr_phase   = 1'b0;
    wr_bad     = 1'b0;
    wr_unknown = 1'b0;
    if (wr_i)
    begin
      unique case (cmd_i)
        ctv_pkg::CMD_SWITCHING_FREQ:
        begin
          wr_freq = (wr_val_f > 0) && (wr_val_f <= ctv_pkg::FREQ_MAX_KHZ);
          wr_bad  = !wr_freq;
        end
        ctv_pkg::CMD_TURN_ON_THR:
        begin
          wr_on  = thr_ok(wr_val_q, ctv_pkg::ON_MIN_Q); // R8 R12
          wr_bad = !wr_on;
        end
        ctv_pkg::CMD_TURN_OFF_THR:
        begin
          wr_off = thr_ok(wr_val_q, ctv_pkg::OFF_MIN_Q); // R9 R12
          wr_bad = !wr_off;
        end
        ctv_pkg::CMD_PHASE_PLACE:
        begin
          wr_phase = writable_r && phase_ok(wdata_i[11:0]); // R17 R15
          wr_bad   = !wr_phase;
        end
        default:
          wr_unknown = 1'b1;
      endcase
    end
  end

  // ******************************
  // Command registers
  // ******************************
  logic [15:0] freq_r;
  logic [15:0] on_r;
  logic [15:0] off_r;
  logic [11:0] phase_r;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      freq_r <= ctv_pkg::FREQ_RST;
    else if (reload)
    begin
      // Stored kHz is re-encoded so the mantissa fits its positive range.
      if (nvm_freq_khz_i < 11'(ctv_pkg::MANT_LIMIT))
        freq_r <= {5'h00, nvm_freq_khz_i}; // R3
      else
        freq_r <= {5'h01, 1'b0, nvm_freq_khz_i[10:1]}; // R3
    end
    else if (wr_freq)
      freq_r <= wdata_i;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      on_r  <= ctv_pkg::THR_RST; // R6
      off_r <= ctv_pkg::THR_RST; // R9
    end
    else if (reload)
    begin
      on_r  <= thr_word(nvm_on_q); // R7
      off_r <= thr_word(nvm_off_q); // R7
    end
    else
    begin
      if (wr_on)
        on_r <= wdata_i;
      if (wr_off)
        off_r <= wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      phase_r <= ctv_pkg::PHASE_RST;
    else if (reload && phase_ok(nvm_phase_i))
      phase_r <= nvm_phase_i;
    else if (wr_phase)
      phase_r <= wdata_i[11:0]; // R14
  end

  // ******************************
  // Hardware settings
  // ******************************
  logic [8:0] deg;

  always_comb
  begin
    unique case (phase_r[ctv_pkg::SIZE_LSB +: 4])
      4'h2:
        deg = 9'(phase_r[1:0] * 9'd180); // R16
      4'h3:
        deg = 9'(phase_r[1:0] * 9'd120); // R16
      4'h4:
        deg = 9'(phase_r[1:0] * 9'd90); // R16
      default:
        deg = 9'h000;
    endcase
  end

  // A running converter keeps its frequency; the new word waits for a supply drop, while a restore applies the stored kHz value.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hw_o.fsw_khz <= 11'd225;
    // The stored word lands at the reload edge, so hardware follows one edge later.
    else if (!conv_en_i || reload_d_r || uvlo_rise)
      hw_o.fsw_khz <= freq_band(lin_fixed(freq_r, 0)); // R2 R4
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hw_o.on_q      <= 7'(ctv_pkg::ON_MIN_Q);
      hw_o.off_q     <= 7'(ctv_pkg::OFF_MIN_Q);
      hw_o.phase_deg <= 9'h000;
    end
    // The reset words decode below the hardware span, so the steps wait for the load.
    else if (boot_r)
    begin
      hw_o.on_q      <= 7'(lin_fixed(on_r, ctv_pkg::THR_FRAC)); // R7 R8
      hw_o.off_q     <= 7'(lin_fixed(off_r, ctv_pkg::THR_FRAC)); // R7 R9
      hw_o.phase_deg <= deg;
    end
  end

  // ******************************
  // Low input supervision
  // ******************************
  logic armed_r;
  logic below_off;

  assign below_off = power_stage_input_q_i < hw_o.off_q;

  // Only power-on reset re-masks; enable toggles and restores leave it armed.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      armed_r <= 1'b0;
    else if (power_stage_input_q_i > hw_o.on_q)
      armed_r <= 1'b1; // R10
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      low_input_fault_o <= 1'b0;
    else
      low_input_fault_o <= armed_r && below_off; // R10
  end

  // ******************************
  // Status flags
  // ******************************
  // A new event in the clearing cycle wins so that nothing is lost.
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      status_o <= '0;
    else
    begin
      if (wr_bad)
        status_o.invalid_data <= 1'b1; // R12
      else if (status_clr_i)
        status_o.invalid_data <= 1'b0;
      if (wr_unknown)
        status_o.invalid_cmd <= 1'b1;
      else if (status_clr_i)
        status_o.invalid_cmd <= 1'b0;
      if (en_cond_met_i && below_off)
        status_o.off_low_input <= 1'b1; // R11
      else if (status_clr_i)
        status_o.off_low_input <= 1'b0;
    end
  end

  // ******************************
  // Read path
  // ******************************
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 16'h0000;
      ack_o   <= 1'b0;
    end
    else
    begin
      ack_o <= wr_i || rd_i;
      if (rd_i)
      begin
        unique case (cmd_i)
          ctv_pkg::CMD_SWITCHING_FREQ:
            rdata_o <= freq_r;
          ctv_pkg::CMD_TURN_ON_THR:
            rdata_o <= on_r;
          ctv_pkg::CMD_TURN_OFF_THR:
            rdata_o <= off_r;
          ctv_pkg::CMD_PHASE_PLACE:
            rdata_o <= {4'h0, phase_r}; // R14
          default:
            rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule // ctv_cmd_regs

// File: verif/ctv_host_model.sv
// Host side model that issues word writes and reads to the command block.
`timescale 1ns/1ns
module ctv_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [15:0] rdata_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [7:0]       cmd_o,
  output logic [15:0]      wdata_o
);
  // ****************************
  // Word transfer
  // ****************************
  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    cmd_o   = 8'h00;
    wdata_o = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] v, output logic ok);
    @(posedge clk_i);
    wr_o    <= w;
    rd_o    <= !w;
    cmd_o   <= c;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    // Released lines show the inverse so a stale word never looks valid.
    cmd_o   <= ~c;
    wdata_o <= ~d;
    @(posedge clk_i);
    v  = rdata_i;
    ok = ack_i;
  endtask
endmodule // ctv_host_model

// File: verif/ctv_cmd_regs_props.sv
// Concurrent checks on the ports of the timing command block.
`timescale 1ns/1ns
module ctv_cmd_regs_props (
  input wire logic                 sys_clk_i,
  input wire logic                 arst_n_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [7:0]           cmd_i,
  input wire logic [15:0]          wdata_i,
  input wire logic                 en_cond_met_i,
  input wire logic [6:0]           power_stage_input_q_i,
  input wire logic [15:0]          rdata_o,
  input wire ctv_pkg::ctv_hw_t     hw_o,
  input wire ctv_pkg::ctv_status_t status_o
);
  // ****************************
  // Properties
  // ****************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  phase_top_zero_a: assert property (
    rd_i && cmd_i == 8'h37 |=> rdata_o[15:12] == 4'h0) else $error("phase top bits set");
  phase_angle_a: assert property (
    hw_o.phase_deg inside {0, 90, 120, 180, 240, 270}) else $error("bad phase angle");
  phase_size_a: assert property (
    wr_i && cmd_i == 8'h37 && wdata_i[7:4] == 4'h0 |=> status_o.invalid_data)
    else $error("size zero accepted");
  on_span_a: assert property (hw_o.on_q inside {[10:73]}) else $error("on step out");
  off_span_a: assert property (hw_o.off_q inside {[9:73]}) else $error("off step out");
  bad_thresh_a: assert property (
    wr_i && cmd_i inside {8'h35, 8'h36} && wdata_i == 16'hf04a |=> status_o.invalid_data)
    else $error("invalid threshold not flagged");
  on_apply_a: assert property (
    wr_i && cmd_i == 8'h35 && wdata_i[15:11] == 5'h1e && wdata_i[10:0] inside {[10:73]}
    |=> ##1 hw_o.on_q == 7'($past(wdata_i, 2))) else $error("turn-on not applied");
  freq_band_a: assert property (
    hw_o.fsw_khz inside {225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500})
    else $error("frequency off band");
  low_input_a: assert property (
    en_cond_met_i && power_stage_input_q_i < hw_o.off_q |-> ##[1:2] status_o.off_low_input)
    else $error("low input not flagged");
endmodule // ctv_cmd_regs_props

bind ctv_cmd_regs ctv_cmd_regs_props i_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .wr_i(wr_i), .rd_i(rd_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .en_cond_met_i(en_cond_met_i),
  .power_stage_input_q_i(power_stage_input_q_i), .rdata_o(rdata_o), .hw_o(hw_o),
  .status_o(status_o));

// File: verif/testbench.sv
// Self-checking bench for the timing and input threshold command registers.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module testbench;
  // ****************************
  // Stimulus and checks
  // ****************************
  logic                 sys_clk = 1'b0, arst_n = 1'b0, conv_en = 1'b0, en_met = 1'b0;
  logic                 restore = 1'b0, uvlo = 1'b0, stacked = 1'b0, sclr = 1'b0;
  logic [10:0]          nf = 11'd400, k, m;
  logic [15:0]          non = 16'hf00b, noff = 16'hf009, e;
  logic [11:0]          nph = 12'h321;
  logic [6:0]           pin = 7'd0, q;
  logic [3:0]           g;
  logic [31:0]          seed = 32'd58;
  logic                 wr, rd, ack, flt;
  logic [7:0]           cmd;
  logic [15:0]          wd, rdata;
  ctv_pkg::ctv_hw_t     hw;
  ctv_pkg::ctv_status_t st;
  int                   checked = 0, miscompares = 0, s, p, i;

  always #5 sys_clk = ~sys_clk;

  ctv_host_model i_host (.clk_i(sys_clk), .ack_i(ack), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .cmd_o(cmd), .wdata_o(wd));
  ctv_cmd_regs i_dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .wr_i(wr), .rd_i(rd),
    .cmd_i(cmd), .wdata_i(wd), .conv_en_i(conv_en), .en_cond_met_i(en_met),
    .nvm_restore_i(restore), .analog_supply_uvlo_i(uvlo), .stacked_i(stacked),
    .nvm_freq_khz_i(nf), .nvm_turn_on_i(non), .nvm_turn_off_i(noff), .nvm_phase_i(nph),
    .power_stage_input_q_i(pin), .status_clr_i(sclr), .rdata_o(rdata), .ack_o(ack),
    .hw_o(hw), .status_o(st), .low_input_fault_o(flt));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [10:0] band(input logic [10:0] f);
    int lim [11] = '{250, 300, 350, 410, 500, 600, 700, 820, 1000, 1200, 1400};
    int val [12] = '{225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500};
    int j;
    j = 0;
    while (j < 11 && f >= lim[j]) j++;
    return 11'(val[j]);
  endfunction

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task strobe(input logic clr);
    if (clr)
      sclr <= 1'b1;
    else
      restore <= 1'b1;
    tick(1);
    sclr    <= 1'b0;
    restore <= 1'b0;
  endtask

  task rst(input logic sk);
    stacked <= sk;
    arst_n  <= 1'b0;
    tick(8);
    arst_n  <= 1'b1;
    tick(3);
  endtask

  task put(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] v;
    logic        ok;
    i_host.xfer(1'b1, c, d, v, ok);
  endtask

  task get(input logic [7:0] c, input logic [15:0] x);
    logic [15:0] v;
    logic        ok;
    i_host.xfer(1'b0, c, 16'h0000, v, ok);
    `CHK({ok, v}, {1'b1, x})
  endtask

  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #200000;
    miscompares++;
    summarize();
  end

  initial
  begin
    rst(1'b0);
    get(8'h33, 16'h0190);
    get(8'h35, 16'hf00b);
    get(8'h36, 16'hf009);
    get(8'h37, 16'h0321);
    `CHK(hw.fsw_khz, 11'd375)
    `CHK(flt, 1'b0)
    $display("restore test done");
    repeat (8)
    begin
      q = 7'(10 + rnd() % 64);
      put(8'h35, {5'h1e, 4'h0, q});
      get(8'h35, {5'h1e, 4'h0, q});
      // Turn-off stays below turn-on so conversion does not chatter.
      m = 11'((q - 1) * 2 + rnd() % 2);
      put(8'h36, {5'h1d, m});
      tick(2);
      `CHK(hw.on_q, q)
      `CHK(hw.off_q, 7'(m >> 1))
    end
    put(8'h35, 16'hf009);
    get(8'h35, {5'h1e, 4'h0, q});
    `CHK(st.invalid_data, 1'b1)
    strobe(1'b1);
    tick(1);
    `CHK(st.invalid_data, 1'b0)
    put(8'h36, 16'hf04a);
    `CHK(st.invalid_data, 1'b1)
    put(8'h20, 16'h1234);
    `CHK(st.invalid_cmd, 1'b1)
    $display("threshold test done");
    // Frequencies stay at or below 1100 kHz since no external bias rail is modelled.
    for (i = 0; i < 10; i++)
    begin
      k = (i == 0) ? 11'd249 : (i == 1) ? 11'd250 : 11'(226 + rnd() % 798);
      e = {5'h00, k};
      put(8'h33, e);
      get(8'h33, e);
      tick(2);
      `CHK(hw.fsw_khz, band(k))
    end
    put(8'h33, {5'h01, 11'd550});
    tick(2);
    `CHK(hw.fsw_khz, 11'd1100)
    conv_en <= 1'b1;
    put(8'h33, 16'h02bc);
    nf <= 11'd700;
    tick(2);
    `CHK(hw.fsw_khz, 11'd1100)
    strobe(1'b0);
    tick(4);
    `CHK(hw.fsw_khz, 11'd750)
    put(8'h33, 16'h012c);
    nf <= 11'd300;
    tick(2);
    `CHK(hw.fsw_khz, 11'd750)
    uvlo <= 1'b1;
    tick(6);
    uvlo <= 1'b0;
    `CHK(hw.fsw_khz, 11'd325)
    conv_en <= 1'b0;
    $display("frequency test done");
    for (s = 1; s <= 4; s++)
      for (p = 0; p < s; p++)
      begin
        g = 4'(rnd());
        put(8'h37, {4'hf, g, 4'(s), 4'(p)});
        get(8'h37, {4'h0, g, 4'(s), 4'(p)});
        tick(2);
        `CHK(hw.phase_deg, 9'(360 / s * p))
      end
    strobe(1'b1);
    put(8'h37, 16'h0200);
    `CHK(st.invalid_data, 1'b1)
    strobe(1'b1);
    put(8'h37, 16'h0122);
    `CHK(st.invalid_data, 1'b1)
    stacked <= 1'b1;
    put(8'h37, 16'h0310);
    get(8'h37, 16'h0310);
    $display("phase test done");
    en_met <= 1'b1;
    tick(4);
    `CHK(st.off_low_input, 1'b1)
    `CHK(flt, 1'b0)
    pin <= 7'd80;
    tick(4);
    pin <= 7'd0;
    tick(4);
    `CHK(flt, 1'b1)
    strobe(1'b0);
    tick(4);
    `CHK(flt, 1'b1)
    rst(1'b1);
    put(8'h37, 16'h0010);
    get(8'h37, 16'h0321);
    `CHK(st.invalid_data, 1'b1)
    stacked <= 1'b0;
    put(8'h37, 16'h0010);
    get(8'h37, 16'h0321);
    $display("stack test done");
    summarize();
  end
endmodule // testbench
